// *** logic/aprs_sequencer.sv ***
// strobe-driven acquire / convert / read sequencer of a 14-bit converter
// assumes strobe, read/convert select and reset pin come from outside the clock domain;
// sample_code_i is the analog core's digital code, valid on the system clock
`include "aprs_params.svh"

// Contract
// RULE_01 - first strobe fall with select low wakes the device and starts acquisition
// RULE_02 - second strobe fall ends acquisition and starts conversion
// RULE_03 - select level at second fall picks shutdown (high) or standby (low)
// RULE_04 - third strobe fall with select high drives the result onto the outputs
// RULE_05 - end-of-conversion flag goes low once a result is available
// RULE_06 - high level on reset input returns the sequence to its start
// RULE_07 - fourteen outputs, bit 13 most significant, bit 0 least significant
// RULE_08 - outputs stay undriven in acquisition and conversion, released on strobe rise
// RULE_09 - after reset with strobe high, next strobe fall begins acquisition
// RULE_10 - host waits 12 ms for reference settling after waking from shutdown
// RULE_11 - host waits for end-of-conversion low before the reading strobe fall
module aprs_sequencer
    import aprs_pkg::*;
#(
    parameter int CONV_CYCLES = `APRS_CONV_CYCLES,
    parameter int REF_WAKE_CYCLES = `APRS_REF_WAKE_CYCLES,
    parameter int FIFO_DEPTH = `APRS_FIFO_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire logic rd_conv_i,
    input wire logic conv_reset_i,
    input wire logic [`APRS_DATA_W-1:0] sample_code_i,
    output logic [`APRS_DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic eoc_n_o,
    output logic ref_on_o,
    output logic ref_ready_o,
    output logic track_o,
    output logic busy_o
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [`APRS_PIN_COUNT-1:0] pin_raw;
    logic [`APRS_PIN_COUNT-1:0] sync_a_reg, sync_a_next;
    logic [`APRS_PIN_COUNT-1:0] sync_b_reg, sync_b_next;
    logic cs_prev_reg, cs_prev_next;
    logic cs_n_s, rd_conv_s, pin_reset_s;
    logic cs_fall, cs_rise;

    assign pin_raw[`APRS_PIN_CS_N] = cs_n_i;
    assign pin_raw[`APRS_PIN_RD_CONV] = rd_conv_i;
    assign pin_raw[`APRS_PIN_RESET] = conv_reset_i;

    always_comb begin
        sync_a_next = pin_raw;
        sync_b_next = sync_a_reg;
        cs_prev_next = sync_b_reg[`APRS_PIN_CS_N];
    end

    // strobe idles high, so the history starts high to avoid a false fall
    genvar gi;
    generate
        for (gi = 0; gi < `APRS_PIN_COUNT; gi++) begin : g_sync
            always_ff @(posedge sys_clk_i) begin
                if (reset_i) begin
                    sync_a_reg[gi] <= (gi == `APRS_PIN_CS_N);
                    sync_b_reg[gi] <= (gi == `APRS_PIN_CS_N);
                end else begin
                    sync_a_reg[gi] <= sync_a_next[gi];
                    sync_b_reg[gi] <= sync_b_next[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cs_prev_reg <= 1'b1;
        end else begin
            cs_prev_reg <= cs_prev_next;
        end
    end

    assign cs_n_s = sync_b_reg[`APRS_PIN_CS_N];
    assign rd_conv_s = sync_b_reg[`APRS_PIN_RD_CONV];
    assign pin_reset_s = sync_b_reg[`APRS_PIN_RESET];
    assign cs_fall = cs_prev_reg && !cs_n_s;
    assign cs_rise = !cs_prev_reg && cs_n_s;

    // ----------------------------------------------------------------
    // result buffer
    // ----------------------------------------------------------------
    aprs_stream_if #(.W(`APRS_DATA_W)) push_s ();
    aprs_stream_if #(.W(`APRS_DATA_W)) pop_s ();

    aprs_fifo #(
        .W(`APRS_DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i || pin_reset_s),
        .in_s(push_s),
        .out_s(pop_s)
    );

    // ----------------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------------
    localparam logic [`APRS_CONV_CNT_W-1:0] CONV_LAST = CONV_CYCLES[`APRS_CONV_CNT_W-1:0] - 1'b1;
    localparam logic [`APRS_WAKE_CNT_W-1:0] WAKE_LAST = REF_WAKE_CYCLES[`APRS_WAKE_CNT_W-1:0] - 1'b1;

    aprs_state_t state_reg, state_next;
    logic [`APRS_CONV_CNT_W-1:0] conv_cnt_reg, conv_cnt_next;
    logic [`APRS_WAKE_CNT_W-1:0] wake_cnt_reg, wake_cnt_next;
    logic [`APRS_DATA_W-1:0] hold_reg, hold_next;
    logic [`APRS_DATA_W-1:0] data_reg, data_next;
    logic shutdown_reg, shutdown_next;
    logic oe_reg, oe_next;
    logic eoc_n_reg, eoc_n_next;
    logic ref_on_reg, ref_on_next;
    logic ref_ready_reg, ref_ready_next;
    logic track_reg, track_next;
    logic busy_reg, busy_next;
    logic read_take;

    // a read strobe takes the oldest buffered result
    assign read_take = (state_reg == ST_IDLE) && cs_fall && rd_conv_s && pop_s.valid;
    assign pop_s.ready = read_take;
    assign push_s.valid = (state_reg == ST_PUSH);
    assign push_s.data = hold_reg;

    always_comb begin
        state_next = state_reg;
        conv_cnt_next = conv_cnt_reg;
        hold_next = hold_reg;
        shutdown_next = shutdown_reg;
        ref_on_next = ref_on_reg;
        track_next = track_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (cs_fall && !rd_conv_s) begin
                    // wake reference and close the track switch
                    state_next = ST_ACQ; // RULE_01
                    ref_on_next = 1'b1; // RULE_01
                    track_next = 1'b1;
                end else if (read_take) begin
                    state_next = ST_READ; // RULE_04
                end
            end
            ST_ACQ: begin
                // the code is held at the instant the track switch opens
                if (cs_fall) begin
                    hold_next = sample_code_i; // RULE_02
                    shutdown_next = rd_conv_s; // RULE_03
                    track_next = 1'b0; // RULE_02
                    conv_cnt_next = '0;
                    state_next = ST_CONV; // RULE_02
                end
            end
            ST_CONV: begin
                // strobe falls here and in ST_PUSH are ignored until the buffer takes the word
                if (conv_cnt_reg == CONV_LAST) begin
                    state_next = ST_PUSH;
                end else begin
                    conv_cnt_next = conv_cnt_reg + 1'b1;
                end
            end
            ST_PUSH: begin
                // a full buffer stalls here and the flag stays low
                if (push_s.ready) begin
                    ref_on_next = !shutdown_reg; // RULE_03
                    state_next = ST_IDLE;
                end
            end
            ST_READ: begin
                if (cs_rise) begin
                    state_next = ST_IDLE; // RULE_08
                end
            end
        endcase
        if (pin_reset_s) begin
            state_next = ST_IDLE; // RULE_06 RULE_09
            track_next = 1'b0;
            ref_on_next = 1'b0;
            shutdown_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_reg <= ST_IDLE;
            conv_cnt_reg <= '0;
            hold_reg <= '0;
            shutdown_reg <= 1'b0;
            ref_on_reg <= 1'b0;
            track_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            conv_cnt_reg <= conv_cnt_next;
            hold_reg <= hold_next;
            shutdown_reg <= shutdown_next;
            ref_on_reg <= ref_on_next;
            track_reg <= track_next;
        end
    end

    // ----------------------------------------------------------------
    // bus drive
    // ----------------------------------------------------------------
    always_comb begin
        data_next = data_reg;
        oe_next = oe_reg;
        // data_o holds the last word; it only means something while enabled
        if (read_take) begin
            // bit i of the buffered word lands on output line i
            data_next = pop_s.data; // RULE_07
            oe_next = 1'b1; // RULE_04
        end else if ((state_reg == ST_READ) && cs_rise) begin
            oe_next = 1'b0; // RULE_08
        end
        // a reset pin mid-read must not leave the bus driven
        if (pin_reset_s) begin
            oe_next = 1'b0; // RULE_08
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            data_reg <= '0;
            oe_reg <= 1'b0;
        end else begin
            data_reg <= data_next;
            oe_reg <= oe_next;
        end
    end

    // ----------------------------------------------------------------
    // flag and busy
    // ----------------------------------------------------------------
    always_comb begin
        // flag follows the buffer, but a read holds it low until strobe rise and forces it high for the cycle after
        if (state_next == ST_READ) begin
            eoc_n_next = eoc_n_reg;
        end else begin
            eoc_n_next = !pop_s.valid && !push_s.valid; // RULE_05
            if (state_reg == ST_READ) begin
                eoc_n_next = 1'b1;
            end
        end
        if (pin_reset_s) begin
            eoc_n_next = 1'b1;
        end
        busy_next = (state_next == ST_CONV) || (state_next == ST_PUSH);
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            eoc_n_reg <= 1'b1;
            busy_reg <= 1'b0;
        end else begin
            eoc_n_reg <= eoc_n_next;
            busy_reg <= busy_next;
        end
    end

    // ----------------------------------------------------------------
    // reference settling
    // ----------------------------------------------------------------
    // settling status only; the host owns the wait before converting
    always_comb begin
        if (!ref_on_next) begin
            wake_cnt_next = '0;
            ref_ready_next = 1'b0;
        end else if (wake_cnt_reg == WAKE_LAST) begin
            wake_cnt_next = wake_cnt_reg;
            ref_ready_next = 1'b1;
        end else begin
            wake_cnt_next = wake_cnt_reg + 1'b1;
            ref_ready_next = ref_ready_reg;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wake_cnt_reg <= '0;
            ref_ready_reg <= 1'b0;
        end else begin
            wake_cnt_reg <= wake_cnt_next;
            ref_ready_reg <= ref_ready_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign data_o = data_reg; // RULE_07
    assign data_oe_o = oe_reg; // RULE_08
    assign eoc_n_o = eoc_n_reg;
    assign ref_on_o = ref_on_reg;
    assign ref_ready_o = ref_ready_reg;
    assign track_o = track_reg;
    assign busy_o = busy_reg;
endmodule

// *** logic/aprs_params.svh ***
// constants of the parallel readout sequencer: widths, depths and timing counts
// assumes a single system clock at the rate given below
`ifndef APRS_PARAMS_SVH
`define APRS_PARAMS_SVH

// ----------------------------------------------------------------
// widths and depths
// ----------------------------------------------------------------
`define APRS_DATA_W 14
`define APRS_MSB 13
`define APRS_LSB 0
`define APRS_FIFO_DEPTH 16
`define APRS_PIN_COUNT 3

// ----------------------------------------------------------------
// pin positions inside the synchroniser vector
// ----------------------------------------------------------------
`define APRS_PIN_CS_N 0
`define APRS_PIN_RD_CONV 1
`define APRS_PIN_RESET 2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define APRS_CLK_MHZ 100
`define APRS_T_CONV_NS 4700
`define APRS_CONV_CYCLES ((`APRS_T_CONV_NS * `APRS_CLK_MHZ) / 1000)
`define APRS_T_REF_WAKE_US 12000
`define APRS_REF_WAKE_CYCLES (`APRS_T_REF_WAKE_US * `APRS_CLK_MHZ)
`define APRS_CONV_CNT_W 16
`define APRS_WAKE_CNT_W 24

`endif

// *** logic/aprs_pkg.sv ***
// types shared by the readout sequencer and its testbench
// assumes aprs_params.svh is on the include path
`include "aprs_params.svh"

package aprs_pkg;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef logic [`APRS_DATA_W-1:0] aprs_word_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACQ,
        ST_CONV,
        ST_PUSH,
        ST_READ
    } aprs_state_t;

endpackage

// *** logic/aprs_stream_if.sv ***
// valid/ready word stream between the sequencer and its result buffer
// assumes both ends run on the same clock
`include "aprs_params.svh"

interface aprs_stream_if #(
    parameter int W = `APRS_DATA_W
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (
        output valid,
        output data,
        input ready
    );

    modport snk (
        input valid,
        input data,
        output ready
    );
endinterface

// *** logic/aprs_fifo.sv ***
// result buffer: width and depth are parameters, read data come from a register
// assumes one clock and a synchronous active-high reset
`include "aprs_params.svh"

module aprs_fifo #(
    parameter int W = `APRS_DATA_W,
    parameter int DEPTH = `APRS_FIFO_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    aprs_stream_if.snk in_s,
    aprs_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
    logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
    logic [AW:0] count_reg, count_next;
    logic [W-1:0] rd_data_reg, rd_data_next;
    logic valid_reg, valid_next;
    logic push, pop;

    // ----------------------------------------------------------------
    // pointers and count
    // ----------------------------------------------------------------
    assign push = in_s.valid && (count_reg != DEPTH[AW:0]);
    assign pop = out_s.ready && valid_reg;
    assign in_s.ready = (count_reg != DEPTH[AW:0]);
    assign out_s.valid = valid_reg;
    assign out_s.data = rd_data_reg;

    always_comb begin
        wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        valid_next = (count_next != '0);
        // bypass: the word being written is not yet in the array
        if (push && (wr_ptr_reg == rd_ptr_next)) begin
            rd_data_next = in_s.data;
        end else begin
            rd_data_next = mem_reg[rd_ptr_next];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_s.data;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            valid_reg <= 1'b0;
            rd_data_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
            valid_reg <= valid_next;
            rd_data_reg <= rd_data_next;
        end
    end
endmodule

// *** verification/aprs_monitor.sv ***
// checker for the readout sequencer, bound to its top-level ports
// assumes one clock domain and the synchronous reset_i of that domain
`include "aprs_params.svh"

module aprs_monitor #(
    parameter int CONV_CYCLES = 4
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire logic rd_conv_i,
    input wire logic conv_reset_i,
    input wire logic [`APRS_DATA_W-1:0] sample_code_i,
    input wire logic [`APRS_DATA_W-1:0] data_o,
    input wire logic data_oe_o,
    input wire logic eoc_n_o,
    input wire logic ref_on_o,
    input wire logic ref_ready_o,
    input wire logic track_o,
    input wire logic busy_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // helper state
    // ----------------------------------------------------------------
    logic [15:0] busy_cnt_reg, busy_cnt_next;
    logic mode_reg, mode_next;
    logic cs_d_reg;

    always_comb begin
        busy_cnt_next = busy_o ? busy_cnt_reg + 16'h0001 : 16'h0000;
        mode_next = mode_reg;
        // select level at the converting strobe fall
        if (cs_d_reg && !cs_n_i && track_o) begin
            mode_next = rd_conv_i;
        end
        if (reset_i) begin
            busy_cnt_next = 16'h0000;
            mode_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        busy_cnt_reg <= busy_cnt_next;
        mode_reg <= mode_next;
        cs_d_reg <= cs_n_i;
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    a_reset_idle_out: assert property ($fell(reset_i) |-> !data_oe_o && eoc_n_o && !track_o && !busy_o && !ref_on_o)
        else $error("outputs not idle after reset");
    a_pin_reset_idle: assert property (conv_reset_i [*4] |=> !track_o && !busy_o && !data_oe_o && eoc_n_o)
        else $error("reset pin did not return sequence to idle");
    a_acq_start: assert property ($fell(cs_n_i) && !rd_conv_i && !track_o && !busy_o && !data_oe_o
        |-> ##[3:5] (track_o && ref_on_o))
        else $error("acquisition did not start");
    a_conv_start: assert property ($fell(cs_n_i) && track_o |-> ##[3:5] (busy_o && !track_o))
        else $error("conversion did not start");
    a_conv_length: assert property (disable iff (reset_i || conv_reset_i) $fell(busy_o) |-> busy_cnt_reg >= CONV_CYCLES)
        else $error("conversion shorter than its count");
    a_eoc_after_conv: assert property (disable iff (reset_i || conv_reset_i) $fell(busy_o) |-> ##[0:1] !eoc_n_o)
        else $error("end flag not low after conversion");
    a_mode_ref_power: assert property (disable iff (reset_i || conv_reset_i)
        $fell(busy_o) |-> ##[0:1] (ref_on_o == !mode_reg))
        else $error("reference power does not follow mode");
    a_read_drive: assert property ($fell(cs_n_i) && rd_conv_i && !eoc_n_o && !track_o && !busy_o
        |-> ##[3:5] data_oe_o)
        else $error("result not driven on read strobe");
    a_bus_release: assert property ($rose(cs_n_i) && data_oe_o |-> ##[3:5] !data_oe_o)
        else $error("bus not released after strobe rise");
    a_hiz_busy: assert property ((track_o || busy_o) |-> !data_oe_o)
        else $error("bus driven during acquisition or conversion");
    a_drive_has_data: assert property (data_oe_o |-> !eoc_n_o)
        else $error("bus driven with no result flagged");
    a_ready_needs_ref: assert property (ref_ready_o |-> ref_on_o)
        else $error("reference settled while powered down");
endmodule

bind aprs_sequencer aprs_monitor #(.CONV_CYCLES(CONV_CYCLES)) u_mon (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .cs_n_i(cs_n_i), .rd_conv_i(rd_conv_i), .conv_reset_i(conv_reset_i), .sample_code_i(sample_code_i),
    .data_o(data_o), .data_oe_o(data_oe_o), .eoc_n_o(eoc_n_o), .ref_on_o(ref_on_o),
    .ref_ready_o(ref_ready_o), .track_o(track_o), .busy_o(busy_o));

// *** verification/aprs_host_model.sv ***
// host controller model: drives strobe, select and reset pin at falling clock edges
// assumes the sequencer samples its pins on the rising edge through synchronisers
module aprs_host_model (
    input wire logic sys_clk_i,
    input wire logic eoc_n_i,
    input wire logic ref_ready_i,
    output logic cs_n_o,
    output logic rd_conv_o,
    output logic conv_reset_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cs_n_o = 1'b1;
        rd_conv_o = 1'b0;
        conv_reset_o = 1'b0;
    end

    // ----------------------------------------------------------------
    // strobe edges
    // ----------------------------------------------------------------
    // select settles 3 cycles ahead, synchronisers delay both pins alike
    task automatic fall(input logic sel);
        rd_conv_o = sel;
        repeat (3) @(negedge sys_clk_i);
        cs_n_o = 1'b0;
        repeat (5) @(negedge sys_clk_i);
    endtask

    task automatic rise();
        cs_n_o = 1'b1;
        repeat (5) @(negedge sys_clk_i);
    endtask

    // ----------------------------------------------------------------
    // waits
    // ----------------------------------------------------------------
    task automatic wait_ref();
        for (int n = 0; n < 64 && ref_ready_i !== 1'b1; n++) @(negedge sys_clk_i);
    endtask

    task automatic wait_eoc();
        for (int n = 0; n < 64 && eoc_n_i !== 1'b0; n++) @(negedge sys_clk_i);
    endtask

    // pin reset only while the strobe is high
    task automatic pulse_reset();
        conv_reset_o = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        conv_reset_o = 1'b0;
        repeat (4) @(negedge sys_clk_i);
    endtask
endmodule

// *** verification/testbench.sv ***
// self-checking bench of the readout sequencer with a host model on its pins
// assumes short counts: 4 conversion cycles and 8 wake cycles
module testbench
    import aprs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk_i = 1'b0;
    logic reset_i;
    wire cs_n, rd, crst;
    aprs_word_t code;
    aprs_word_t data;
    logic oe, eoc_n, ref_on, ref_rdy, track, busy;
    int fails = 0;
    int checks = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    aprs_sequencer #(.CONV_CYCLES(4), .REF_WAKE_CYCLES(8)) dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .cs_n_i(cs_n), .rd_conv_i(rd), .conv_reset_i(crst), .sample_code_i(code), .data_o(data),
        .data_oe_o(oe), .eoc_n_o(eoc_n), .ref_on_o(ref_on), .ref_ready_o(ref_rdy), .track_o(track),
        .busy_o(busy));
    aprs_host_model host (.sys_clk_i(sys_clk_i), .eoc_n_i(eoc_n), .ref_ready_i(ref_rdy), .cs_n_o(cs_n),
        .rd_conv_o(rd), .conv_reset_o(crst));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(string what, logic [13:0] seen, logic [13:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic aprs_word_t word(int i);
        return 14'h2A5A ^ (14'(i) * 14'h0123);
    endfunction

    task automatic convert(aprs_word_t c, logic mode);
        host.fall(1'b0);
        check("track", 14'(track), 14'h0001);
        check("ref_on", 14'(ref_on), 14'h0001);
        check("oe acq", 14'(oe), 14'h0000);
        host.wait_ref();
        check("ref ready", 14'(ref_rdy), 14'h0001);
        host.rise();
        code = c;
        host.fall(mode);
        check("busy", 14'(busy), 14'h0001);
        check("track conv", 14'(track), 14'h0000);
        check("oe conv", 14'(oe), 14'h0000);
        host.rise();
        for (int n = 0; n < 50 && busy !== 1'b0; n++) @(negedge sys_clk_i);
        @(negedge sys_clk_i);
        check("eoc", 14'(eoc_n), 14'h0000);
        check("ref mode", 14'(ref_on), 14'(!mode));
        check("ref ready mode", 14'(ref_rdy), 14'(!mode));
    endtask

    task automatic read(aprs_word_t exp);
        host.wait_eoc();
        host.fall(1'b1);
        check("oe read", 14'(oe), 14'h0001);
        check("data", data, exp);
        host.rise();
        check("oe release", 14'(oe), 14'h0000);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_refused();
        host.fall(1'b1);
        check("track refused", 14'(track), 14'h0000);
        check("oe empty", 14'(oe), 14'h0000);
        host.rise();
    endtask

    task automatic t_modes();
        convert(14'h2000, 1'b0);
        read(14'h2000);
        convert(14'h0001, 1'b1);
        read(14'h0001);
        check("eoc empty", 14'(eoc_n), 14'h0001);
    endtask

    // oldest word comes out first
    task automatic t_fill_drain();
        for (int i = 0; i < 16; i++) convert(word(i), 1'b0);
        for (int i = 0; i < 16; i++) read(word(i));
        check("eoc drained", 14'(eoc_n), 14'h0001);
    endtask

    // a full buffer deadlocks the sequence; only the pin reset or reset_i frees it
    task automatic t_stall_reset();
        for (int i = 0; i < 16; i++) convert(word(i + 16), 1'b1);
        host.fall(1'b0);
        host.rise();
        host.fall(1'b0);
        host.rise();
        repeat (20) @(negedge sys_clk_i);
        check("busy full", 14'(busy), 14'h0001);
        host.pulse_reset();
        check("busy reset", 14'(busy), 14'h0000);
        check("eoc reset", 14'(eoc_n), 14'h0001);
        t_refused();
        convert(14'h3FFF, 1'b0);
        read(14'h3FFF);
    endtask

    task automatic t_sysreset();
        host.fall(1'b0);
        reset_i = 1'b1;
        host.rise();
        reset_i = 1'b0;
        @(negedge sys_clk_i);
        check("track sysrst", 14'(track), 14'h0000);
        check("ref sysrst", 14'(ref_on), 14'h0000);
        convert(14'h1234, 1'b0);
        read(14'h1234);
    endtask

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        reset_i = 1'b1;
        code = 14'h0000;
        repeat (12) @(negedge sys_clk_i);
        reset_i = 1'b0;
        @(negedge sys_clk_i);
        check("oe rst", 14'(oe), 14'h0000);
        check("eoc rst", 14'(eoc_n), 14'h0001);
        check("ref rst", 14'(ref_on), 14'h0000);
        t_refused();
        t_modes();
        t_fill_drain();
        t_stall_reset();
        t_sysreset();
        tally_and_finish();
    end

    // about 40 conversions of some 50 cycles each
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fails++;
        tally_and_finish();
    end
endmodule
